// [apc_pkg.sv]
// Package for the audio path configuration register bank.
// Assumes a single 50 MHz core clock; bit positions are those of the three config words.
package apc_pkg;
  localparam int          WORD_W        = 16;
  localparam int          SEL_W         = 2;
  // Word selector on the load port
  localparam logic [1:0]  SEL_WORD_A    = 2'h0;
  localparam logic [1:0]  SEL_WORD_B    = 2'h1;
  localparam logic [1:0]  SEL_WORD_C    = 2'h2;
  // Reset values: all zero, so every stage comes up enabled until the host loads a set
  localparam logic [15:0] WORD_A_RESET  = 16'h0000;
  localparam logic [15:0] WORD_B_RESET  = 16'h0000;
  localparam logic [15:0] WORD_C_RESET  = 16'h0000;
  // Word A fields
  localparam int A_ATTEN_PD     = 0;
  localparam int A_OUT_STAGE_LO = 1;
  localparam int A_OUT_STAGE_HI = 2;
  localparam int A_OUT_PATH_LO  = 3;
  localparam int A_OUT_PATH_HI  = 4;
  localparam int A_COMPRESS     = 7;
  localparam int A_OSC_PD       = 8;
  localparam int A_INPUT_SRC    = 9;
  // Word B fields
  localparam int B_GAIN_AMP_PD  = 0;
  localparam int B_LOWPASS_PD   = 1;
  localparam int B_RATE_LO      = 2;
  localparam int B_RATE_HI      = 3;
  localparam int B_FILTER_SEL   = 4;
  localparam int B_MIX2_LO      = 5;
  localparam int B_MIX2_HI      = 6;
  localparam int B_MIX1_LO      = 7;
  localparam int B_MIX1_HI      = 8;
  localparam int B_MIX1_SRC_LO  = 9;
  localparam int B_MIX1_SRC_HI  = 10;
  localparam int B_ATTEN_LSB    = 11;
  localparam int B_ATTEN_MSB    = 13;
  localparam int B_VOL_SRC_LO   = 14;
  localparam int B_VOL_SRC_HI   = 15;
  // Word C fields
  localparam int C_ADC_PD       = 0;
  localparam int C_DAC_PD       = 1;
  localparam int C_IFACE_SEL    = 4;
  // Sample rate codes {hi,lo}
  localparam logic [1:0] RATE_8K0 = 2'h0;
  localparam logic [1:0] RATE_6K4 = 2'h1;
  localparam logic [1:0] RATE_5K3 = 2'h2;
  // Two-bit mixer control codes {hi,lo}
  localparam logic [1:0] MIX_PASS_LO_ONLY = 2'h1;
  localparam logic [1:0] MIX_PASS_HI_ONLY = 2'h2;
  localparam logic [1:0] MIX_POWER_DOWN   = 2'h3;
  typedef enum logic [2:0] {
    APC_LOAD_IDLE = 3'b001,
    APC_LOAD_NEXT = 3'b010,
    APC_LOAD_LAST = 3'b100
  } apc_load_t;
endpackage

// [apc_config_regs.sv]
// Audio path configuration register bank: three 16-bit words and their decoded controls.
// Assumes the serial control front end presents each word with a one-cycle strobe,
// already synchronous to core_clk and issued on the serial clock's rising edge.
`timescale 1ns/1ps
module apc_config_regs #(
  parameter int WORD_WIDTH = 16
) (
  input  wire logic                       core_clk,
  input  wire logic                       nrst,
  input  wire logic                       word_load,
  input  wire logic [apc_pkg::SEL_W-1:0]  word_sel,
  input  wire logic [WORD_WIDTH-1:0]      word_data,
  output logic      [WORD_WIDTH-1:0]      path_config_word_a,
  output logic      [WORD_WIDTH-1:0]      path_config_word_b,
  output logic      [WORD_WIDTH-1:0]      path_config_word_c,
  output logic                            load_order_error,
  output logic                            load_set_complete,
  output logic      [1:0]                 mixer_one_source,
  output logic                            mixer_one_pass_selector,
  output logic                            mixer_one_pass_input_src,
  output logic                            mixer_one_power_down,
  output logic                            filter_input_sel,
  output logic                            compression_ctl,
  output logic                            lowpass_power_down,
  output logic      [1:0]                 sample_rate_code,
  output logic                            sample_rate_valid,
  output logic                            mixer_two_pass_filter,
  output logic                            mixer_two_power_down,
  output logic                            gain_amp_power_down,
  output logic                            input_source_sel,
  output logic                            oscillator_power_down,
  output logic      [1:0]                 attenuator_source,
  output logic                            attenuator_power_down,
  output logic      [2:0]                 attenuation_code,
  output logic      [1:0]                 output_path,
  output logic      [1:0]                 output_stage_ctl,
  output logic                            adc_power_down,
  output logic                            dac_power_down,
  output logic                            audio_iface_sel
);
  import apc_pkg::*;

  // Field positions and the word selector assume sixteen-bit words
  if (WORD_WIDTH != WORD_W)
  begin : g_width_check
    $error("apc_config_regs: WORD_WIDTH must be 16");
  end

  apc_load_t load_state;
  apc_load_t next_load_state;

  // True when a two-bit control field holds the given code
  function automatic logic field_is(input logic [1:0] field, input logic [1:0] code);
    return field == code;
  endfunction

  // Two-bit summing-mixer controls, each decoded more than once
  logic [1:0] mix_one_ctl;
  logic [1:0] mix_two_ctl;

  assign mix_one_ctl = path_config_word_b[B_MIX1_HI:B_MIX1_LO];
  assign mix_two_ctl = path_config_word_b[B_MIX2_HI:B_MIX2_LO];

  // Word storage: every written bit is kept until overwritten; select code 3 writes nothing
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      path_config_word_a <= WORD_A_RESET;
    else if (word_load && (word_sel == SEL_WORD_A))
      path_config_word_a <= word_data;
  end

  // Word B: mixers, filter, rate and volume
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      path_config_word_b <= WORD_B_RESET;
    else if (word_load && (word_sel == SEL_WORD_B))
      path_config_word_b <= word_data;
  end

  // Word C: converter power and audio interface mode
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      path_config_word_c <= WORD_C_RESET;
    else if (word_load && (word_sel == SEL_WORD_C))
      path_config_word_c <= word_data;
  end

  // Load sequence tracker: expects A then B then C
  always_comb
  begin
    next_load_state = load_state;
    if (word_load)
    begin
      // A stray word B from idle is taken as the middle of a broken set
      case (load_state)
        APC_LOAD_IDLE:
        begin
          if (word_sel == SEL_WORD_B)
            next_load_state = APC_LOAD_LAST;
          else if (word_sel == SEL_WORD_A)
            next_load_state = APC_LOAD_NEXT;
          else
            next_load_state = APC_LOAD_IDLE;
        end
        APC_LOAD_NEXT:
        begin
          if (word_sel == SEL_WORD_B)
            next_load_state = APC_LOAD_LAST;
          else if (word_sel == SEL_WORD_A)
            next_load_state = APC_LOAD_NEXT;
          else
            next_load_state = APC_LOAD_IDLE;
        end
        APC_LOAD_LAST:
        begin
          if (word_sel == SEL_WORD_A)
            next_load_state = APC_LOAD_NEXT;
          else
            next_load_state = APC_LOAD_IDLE;
        end
        default:
          next_load_state = APC_LOAD_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      load_state <= APC_LOAD_IDLE;
    else
      load_state <= next_load_state;
  end

  // Sticky flag for an out-of-order load; cleared by a word A loaded while the tracker is idle
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      load_order_error <= 1'b0;
    else if (word_load)
    begin
      case (load_state)
        APC_LOAD_IDLE: load_order_error <= (word_sel != SEL_WORD_A);
        APC_LOAD_NEXT: load_order_error <= load_order_error | (word_sel != SEL_WORD_B);
        APC_LOAD_LAST: load_order_error <= load_order_error | (word_sel != SEL_WORD_C);
        default:       load_order_error <= 1'b1;
      endcase
    end
  end

  // One-cycle pulse after word C completes an A, B, C set
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      load_set_complete <= 1'b0;
    else
      load_set_complete <= word_load && (load_state == APC_LOAD_LAST)
                           && (word_sel == SEL_WORD_C) && !load_order_error;
  end

  // Decoded controls follow their stored word one edge later;
  // their reset values equal the decode of an all-zero word.
  // Mixer one: source selector and summing control
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mixer_one_source         <= 2'h0;
      mixer_one_pass_selector  <= 1'b0;
      mixer_one_pass_input_src <= 1'b0;
      mixer_one_power_down     <= 1'b0;
    end
    else
    begin
      mixer_one_source         <= path_config_word_b[B_MIX1_SRC_HI:B_MIX1_SRC_LO];
      mixer_one_pass_selector  <= field_is(mix_one_ctl, MIX_PASS_LO_ONLY);
      mixer_one_pass_input_src <= field_is(mix_one_ctl, MIX_PASS_HI_ONLY);
      mixer_one_power_down     <= field_is(mix_one_ctl, MIX_POWER_DOWN);
    end
  end

  // Filter input multiplexer and low-pass stage power
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      filter_input_sel   <= 1'b0;
      lowpass_power_down <= 1'b0;
    end
    else
    begin
      filter_input_sel   <= path_config_word_b[B_FILTER_SEL];
      lowpass_power_down <= path_config_word_b[B_LOWPASS_PD];
    end
  end

  // Sample rate; code 11 names no rate, so the valid flag drops for it
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sample_rate_code  <= RATE_8K0;
      sample_rate_valid <= 1'b1;
    end
    else
    begin
      sample_rate_code  <= path_config_word_b[B_RATE_HI:B_RATE_LO];
      sample_rate_valid <= (path_config_word_b[B_RATE_HI:B_RATE_LO] != 2'h3);
    end
  end

  // Mixer two summing control
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mixer_two_pass_filter <= 1'b0;
      mixer_two_power_down  <= 1'b0;
    end
    else
    begin
      mixer_two_pass_filter <= field_is(mix_two_ctl, MIX_PASS_HI_ONLY);
      mixer_two_power_down  <= field_is(mix_two_ctl, MIX_POWER_DOWN);
    end
  end

  // Automatic gain amplifier power
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      gain_amp_power_down <= 1'b0;
    else
      gain_amp_power_down <= path_config_word_b[B_GAIN_AMP_PD];
  end

  // Volume stage: source and level sit in word B, its power in word A
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      attenuator_source     <= 2'h0;
      attenuation_code      <= 3'h0;
      attenuator_power_down <= 1'b0;
    end
    else
    begin
      attenuator_source     <= path_config_word_b[B_VOL_SRC_HI:B_VOL_SRC_LO];
      attenuation_code      <= path_config_word_b[B_ATTEN_MSB:B_ATTEN_LSB];
      attenuator_power_down <= path_config_word_a[A_ATTEN_PD];
    end
  end

  // Signal compression
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      compression_ctl <= 1'b0;
    else
      compression_ctl <= path_config_word_a[A_COMPRESS];
  end

  // Input source multiplexer
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      input_source_sel <= 1'b0;
    else
      input_source_sel <= path_config_word_a[A_INPUT_SRC];
  end

  // Sampling oscillator power
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      oscillator_power_down <= 1'b0;
    else
      oscillator_power_down <= path_config_word_a[A_OSC_PD];
  end

  // Output multiplexer and speaker / auxiliary stages
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      output_path      <= 2'h0;
      output_stage_ctl <= 2'h0;
    end
    else
    begin
      output_path      <= path_config_word_a[A_OUT_PATH_HI:A_OUT_PATH_LO];
      output_stage_ctl <= path_config_word_a[A_OUT_STAGE_HI:A_OUT_STAGE_LO];
    end
  end

  // Converter power
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      adc_power_down <= 1'b0;
      dac_power_down <= 1'b0;
    end
    else
    begin
      adc_power_down <= path_config_word_c[C_ADC_PD];
      dac_power_down <= path_config_word_c[C_DAC_PD];
    end
  end

  // Audio interface mode
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      audio_iface_sel <= 1'b0;
    else
      audio_iface_sel <= path_config_word_c[C_IFACE_SEL];
  end

endmodule

// [apc_config_regs_asserts.sv]
// Checker for the configuration word bank: storage, hold and field decodes.
// Bound to apc_config_regs; sees only its ports, one core_clk domain.
`timescale 1ns/1ps
module apc_config_regs_chk
  import apc_pkg::*;
#(
  parameter int WORD_WIDTH = 16
) (
  input wire logic                  core_clk, nrst, word_load, load_set_complete,
  input wire logic [SEL_W-1:0]      word_sel,
  input wire logic [WORD_WIDTH-1:0] word_data, path_config_word_a,
  input wire logic [WORD_WIDTH-1:0] path_config_word_b, path_config_word_c,
  input wire logic [1:0]            mixer_one_source, sample_rate_code, attenuator_source,
  input wire logic [1:0]            output_path, output_stage_ctl,
  input wire logic [2:0]            attenuation_code,
  input wire logic                  mixer_one_pass_selector, mixer_one_pass_input_src,
  input wire logic                  mixer_one_power_down, filter_input_sel, compression_ctl,
  input wire logic                  lowpass_power_down, sample_rate_valid, load_order_error,
  input wire logic                  mixer_two_pass_filter, mixer_two_power_down,
  input wire logic                  gain_amp_power_down, input_source_sel, oscillator_power_down,
  input wire logic                  attenuator_power_down, adc_power_down, dac_power_down,
  input wire logic                  audio_iface_sel
);
  logic [WORD_WIDTH-1:0] pa, pb, pc;

  // Words one cycle back, which the decodes must follow
  always_ff @(posedge core_clk)
  begin
    pa <= path_config_word_a;
    pb <= path_config_word_b;
    pc <= path_config_word_c;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_word_a_load: assert property (word_load && word_sel == SEL_WORD_A |=>
    path_config_word_a == $past(word_data)) else $error("word A not stored");
  a_word_b_load: assert property (word_load && word_sel == SEL_WORD_B |=>
    path_config_word_b == $past(word_data)) else $error("word B not stored");
  a_word_c_load: assert property (word_load && word_sel == SEL_WORD_C |=>
    path_config_word_c == $past(word_data)) else $error("word C not stored");
  a_word_b_keep: assert property (!(word_load && word_sel == SEL_WORD_B) |=>
    $stable(path_config_word_b)) else $error("word B changed without load");
  a_word_a_keep: assert property (!(word_load && word_sel == SEL_WORD_A) |=>
    $stable(path_config_word_a)) else $error("word A changed without load");
  a_word_c_keep: assert property (!(word_load && word_sel == SEL_WORD_C) |=>
    $stable(path_config_word_c)) else $error("word C changed without load");
  a_done_pulse: assert property (load_set_complete |->
    $past(word_load && word_sel == SEL_WORD_C) && !$past(load_order_error))
    else $error("set complete without a clean word C");
  a_mix_one_dec: assert property (mixer_one_source == pb[10:9] &&
    mixer_one_power_down == &pb[8:7] && mixer_one_pass_selector == (pb[8:7] == 2'h1) &&
    mixer_one_pass_input_src == (pb[8:7] == 2'h2)) else $error("mixer one decode wrong");
  a_rate_dec: assert property (sample_rate_code == pb[3:2] && lowpass_power_down == pb[1] &&
    sample_rate_valid == (pb[3:2] != 2'h3)) else $error("rate decode wrong");
  a_mix_two_dec: assert property (mixer_two_power_down == &pb[6:5] &&
    mixer_two_pass_filter == (pb[6:5] == 2'h2) && filter_input_sel == pb[4])
    else $error("mixer two decode wrong");
  a_volume_dec: assert property ({attenuator_source, attenuation_code} == pb[15:11] &&
    gain_amp_power_down == pb[0]) else $error("volume decode wrong");
  a_word_a_dec: assert property ({input_source_sel, oscillator_power_down, compression_ctl}
    == pa[9:7] && {output_path, output_stage_ctl, attenuator_power_down} == pa[4:0])
    else $error("word A decode wrong");
  a_word_c_dec: assert property ({audio_iface_sel, dac_power_down, adc_power_down} ==
    {pc[4], pc[1:0]}) else $error("word C decode wrong");

  c_set_done: cover property (load_set_complete);
  c_order_err: cover property (load_order_error && word_load);
  c_sel_unused: cover property (word_load && word_sel == 2'h3);
  c_rate_bad: cover property (!sample_rate_valid);
endmodule

// [apc_host.sv]
// Host model: loads configuration words on the strobe port.
// Assumes drives change at the falling edge of core_clk.
`timescale 1ns/1ps
module apc_host
  import apc_pkg::*;
(
  input  wire logic        core_clk,
  output logic             word_load,
  output logic [SEL_W-1:0] word_sel,
  output logic [15:0]      word_data
);
  initial
  begin
    word_load = 1'b0;
    word_sel  = 2'h0;
    word_data = 16'h0000;
  end

  // Back-to-back calls keep the strobe high, one word per cycle
  task automatic send(input logic [1:0] sel, input logic [15:0] data);
    @(negedge core_clk);
    word_load <= 1'b1;
    word_sel  <= sel;
    word_data <= data;
  endtask

  // Released bus shows no stale value
  task automatic idle();
    @(negedge core_clk);
    word_load <= 1'b0;
    word_sel  <= ~word_sel;
    word_data <= ~word_data;
  endtask

  task automatic load_set(input logic [15:0] a, b, c);
    send(SEL_WORD_A, a);
    send(SEL_WORD_B, b);
    send(SEL_WORD_C, c);
  endtask
endmodule

// [apc_config_regs_tb.sv]
// Testbench for the configuration word bank: four path setups, order, refusal, reset.
// Assumes the host model drives the load port; checker is bound below.
`timescale 1ns/1ps
module apc_config_regs_tb;
  import apc_pkg::*;
  logic        core_clk, nrst, word_load, load_order_error, load_set_complete;
  logic [1:0]  word_sel, mixer_one_source, sample_rate_code, attenuator_source, output_path;
  logic [1:0]  output_stage_ctl;
  logic [2:0]  attenuation_code;
  logic [15:0] word_data, path_config_word_a, path_config_word_b, path_config_word_c;
  logic        mixer_one_pass_selector, mixer_one_pass_input_src, mixer_one_power_down;
  logic        filter_input_sel, compression_ctl, lowpass_power_down, sample_rate_valid;
  logic        mixer_two_pass_filter, mixer_two_power_down, gain_amp_power_down;
  logic        input_source_sel, oscillator_power_down, attenuator_power_down;
  logic        adc_power_down, dac_power_down, audio_iface_sel;
  logic [28:0] dec;
  int          fail_count = 0;
  int          cmp_count = 0;

  assign dec = {mixer_one_source, mixer_one_pass_selector, mixer_one_pass_input_src,
    mixer_one_power_down, filter_input_sel, compression_ctl, lowpass_power_down,
    sample_rate_code, sample_rate_valid, mixer_two_pass_filter, mixer_two_power_down,
    gain_amp_power_down, input_source_sel, oscillator_power_down, attenuator_source,
    attenuator_power_down, attenuation_code, output_path, output_stage_ctl,
    adc_power_down, dac_power_down, audio_iface_sel};

  apc_host host (.core_clk(core_clk), .word_load(word_load), .word_sel(word_sel),
    .word_data(word_data));
  apc_config_regs dut (.*);

  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  function automatic logic [28:0] exp_dec(input logic [15:0] a, b, c);
    return {b[10:9], b[8:7] == 2'h1, b[8:7] == 2'h2, &b[8:7], b[4], a[7], b[1], b[3:2],
      b[3:2] != 2'h3, b[6:5] == 2'h2, &b[6:5], b[0], a[9], a[8], b[15:14], a[0], b[13:11],
      a[4:3], a[2:1], c[0], c[1], c[4]};
  endfunction

  task automatic chk(input string what, input logic [28:0] exp, got);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic t_reset(input int n);
    @(negedge core_clk);
    nrst = 1'b0;
    repeat (n) @(negedge core_clk);
    chk("reset_words", 16'h0000, path_config_word_a | path_config_word_b | path_config_word_c);
    chk("reset_dec", exp_dec(16'h0000, 16'h0000, 16'h0000), dec);
    nrst = 1'b1;
  endtask

  task automatic t_mode(input logic [15:0] a, b, c);
    host.load_set(a, b, c);
    host.idle();
    chk("set_done", 1'b1, load_set_complete);
    @(negedge core_clk);
    chk("set_done_low", 1'b0, load_set_complete);
    chk("order_ok", 1'b0, load_order_error);
    chk("words", {a[12:0], b}, {path_config_word_a[12:0], path_config_word_b});
    chk("word_a", a, path_config_word_a);
    chk("word_c", c, path_config_word_c);
    chk("decodes", exp_dec(a, b, c), dec);
  endtask

  task automatic t_feed();
    t_mode(16'h254b, 16'h01e3, 16'h0040);
    chk("feed_pd", 4'hf, {mixer_one_power_down, mixer_two_power_down, lowpass_power_down,
      oscillator_power_down});
    chk("feed_out", 4'h5, {output_path, output_stage_ctl});
  endtask

  task automatic t_call();
    t_mode(16'h440b, 16'h00c5, 16'h0040);
    chk("call_rate", 2'h1, sample_rate_code);
    chk("call_mix", 4'h3, {mixer_one_source, mixer_one_pass_selector,
      mixer_two_pass_filter});
  endtask

  task automatic t_order();
    host.send(SEL_WORD_B, 16'h123c);
    host.send(2'h3, 16'hffff);
    host.idle();
    @(negedge core_clk);
    chk("order_err", 1'b1, load_order_error);
    chk("order_no_done", 1'b0, load_set_complete);
    chk("ooo_b", 16'h123c, path_config_word_b);
    chk("rate_invalid", 1'b0, sample_rate_valid);
    chk("sel_unused", {16'h440b, 13'h0040}, {path_config_word_a, path_config_word_c[12:0]});
  endtask

  task automatic t_memo();
    t_mode(16'h0401, 16'h0148, 16'h0003);
    chk("memo", 6'h28, {sample_rate_code, mixer_one_pass_input_src, input_source_sel,
      gain_amp_power_down, oscillator_power_down});
  endtask

  task automatic t_play();
    t_mode(16'h2422, 16'h59d1, 16'h0003);
    chk("play_vol", 12'h6a4, {attenuation_code, attenuator_source, output_stage_ctl,
      output_path, filter_input_sel, sample_rate_code});
  endtask

  initial
  begin
    nrst = 1'b0;
    t_reset(20);
    t_feed();
    t_call();
    t_order();
    t_memo();
    t_reset(3);
    t_play();
    close_out();
  end

  initial
  begin
    #20000;
    fail_count++;
    close_out();
  end
endmodule

bind apc_config_regs apc_config_regs_chk #(.WORD_WIDTH(WORD_WIDTH)) u_chk (.*);
